/* File: design/upwb_pkg.sv */
// Constants and types for the upstream window 1 base address decode block.
package upwb_pkg;

    // Byte offsets of the registers on the configuration bus.
    localparam logic [7:0]  UPWB_BASE_OFS   = 8'h58;
    localparam logic [7:0]  UPWB_XBASE_OFS  = 8'he8;
    localparam logic [7:0]  UPWB_SETUP_OFS  = 8'hec;

    // Field positions in the setup register; the base register shares all but the enable bit.
    localparam int          UPWB_SPACE_BIT  = 0;
    localparam int          UPWB_TYPE_LSB   = 1;
    localparam int          UPWB_TYPE_MSB   = 2;
    localparam int          UPWB_PREF_BIT   = 3;
    localparam int          UPWB_ADDR_LSB   = 6;
    localparam int          UPWB_ENABLE_BIT = 31;

    // Reset values.
    localparam logic [31:0] UPWB_BASE_RST   = 32'h0000_0000;
    localparam logic [31:0] UPWB_SETUP_RST  = 32'h0000_0000;
    localparam logic [31:0] UPWB_XBASE_RST  = 32'h0000_0000;

    // Attribute bits of the base register that mirror the setup register.
    localparam logic [31:0] UPWB_ATTR_MASK  = 32'h0000_000f;
    // Address bits that may ever take part in the compare.
    localparam logic [31:0] UPWB_ADDR_MASK  = 32'hffff_ffc0;
    // Memory window: 4KB smallest, 2GB largest.
    localparam logic [31:0] UPWB_MEM_LEGAL  = 32'hffff_f000;
    localparam logic [31:0] UPWB_MEM_FIXED  = 32'h8000_0000;
    // I/O window: 64 bytes smallest, 256 bytes largest.
    localparam logic [31:0] UPWB_IO_LEGAL   = 32'hffff_ffc0;
    localparam logic [31:0] UPWB_IO_FIXED   = 32'hffff_ff00;

    typedef enum logic [2:0] {
        UPWB_IDLE   = 3'b001,
        UPWB_ACCESS = 3'b010,
        UPWB_DONE   = 3'b100
    } upwb_state_type;

endpackage

/* File: design/upwb_if.sv */
// Carriers between the bus port, the register bank and the window decoder.
`timescale 1ns/1ns
interface upwb_reg_if;
    logic        acc_stb;
    logic        acc_wr;
    logic [7:0]  acc_addr;
    logic [31:0] acc_wdata;
    logic [3:0]  acc_be;
    modport port (output acc_stb, output acc_wr, output acc_addr, output acc_wdata,
                  output acc_be);
    modport regs (input acc_stb, input acc_wr, input acc_addr, input acc_wdata,
                  input acc_be);
endinterface

interface upwb_win_if;
    logic        enable;
    logic        is_io;
    logic [31:0] mask;
    logic [31:0] base;
    logic [31:0] xbase;
    modport regs (output enable, output is_io, output mask, output base, output xbase);
    modport dec (input enable, input is_io, input mask, input base, input xbase);
endinterface

/* File: design/upwb_bus_port.sv */
// Avalon-MM slave handshake that turns bus requests into single access strobes.
`timescale 1ns/1ns
module upwb_bus_port (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic             waitrequest,
    upwb_reg_if.port         rif
);
    import upwb_pkg::*;

    upwb_state_type state_ff;
    logic           wait_ff;
    logic           wr_ff;
    logic [7:0]     addr_ff;
    logic [31:0]    wdata_ff;
    logic [3:0]     be_ff;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_ff <= UPWB_IDLE;
            wait_ff  <= 1'b1;
        end else begin
            case (state_ff)
                UPWB_IDLE: begin
                    if (read || write) begin
                        state_ff <= UPWB_ACCESS;
                    end
                end
                UPWB_ACCESS: begin
                    state_ff <= UPWB_DONE;
                    wait_ff  <= 1'b0;
                end
                UPWB_DONE: begin
                    state_ff <= UPWB_IDLE;
                    wait_ff  <= 1'b1;
                end
                default: begin
                    state_ff <= UPWB_IDLE;
                    wait_ff  <= 1'b1;
                end
            endcase
        end
    end

    // The request is captured once so the bank sees a steady access.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ff    <= 1'b0;
            addr_ff  <= 8'h00;
            wdata_ff <= 32'h0000_0000;
            be_ff    <= 4'h0;
        end else if (state_ff == UPWB_IDLE && (read || write)) begin
            wr_ff    <= write;
            addr_ff  <= address;
            wdata_ff <= writedata;
            be_ff    <= byteenable;
        end
    end

    assign waitrequest   = wait_ff;
    assign rif.acc_stb   = (state_ff == UPWB_ACCESS);
    assign rif.acc_wr    = wr_ff;
    assign rif.acc_addr  = addr_ff;
    assign rif.acc_wdata = wdata_ff;
    assign rif.acc_be    = be_ff;

endmodule

/* File: design/upwb_decode.sv */
// Upstream window hit check and direct address translation.
`timescale 1ns/1ns
module upwb_decode (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    upwb_win_if.dec          win,
    input  wire logic        up_valid,
    input  wire logic        up_is_io,
    input  wire logic [31:0] up_addr,
    output logic             hit,
    output logic [31:0]      xlat_addr
);
    import upwb_pkg::*;

    logic        hit_ff;
    logic [31:0] xlat_ff;
    logic        match;

    assign match = win.enable && (up_is_io == win.is_io)
                   && (((up_addr ^ win.base) & win.mask) == 32'h0000_0000);

    // Window bits come from the translated base, offset bits pass through.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            hit_ff  <= 1'b0;
            xlat_ff <= 32'h0000_0000;
        end else begin
            hit_ff  <= up_valid && match;
            xlat_ff <= (win.xbase & win.mask) | (up_addr & ~win.mask);
        end
    end

    assign hit       = hit_ff;
    assign xlat_addr = xlat_ff;

endmodule

/* File: design/upwb_top.sv */
// Register bank for the upstream window 1 base address and its setup.
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ns
// What this block does
// [RL1] Bit 0 reads space type, memory or I/O.
// [RL2] Bits 2:1 read the decode width field.
// [RL3] Bit 3 reads the prefetchable flag.
// [RL4] Base bits writable only where setup allows.
// [RL5] Window size and type come from setup.
// [RL6] Setup loadable from an external loader.
// [RL7] Setup bit 31 clear disables the window.
// [RL8] Memory window spans 4KB up to 2GB.
// [RL9] I/O window spans 64 up to 256 bytes.
// [RL10] Hits translate through the translated base.
// [RL11] Reserved bits 5:4 read zero, ignore writes.
module upwb_top (
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    input  wire logic        ld_valid,
    input  wire logic [31:0] ld_data,
    input  wire logic        up_valid,
    input  wire logic        up_is_io,
    input  wire logic [31:0] up_addr,
    output logic             up_hit,
    output logic [31:0]      up_xlat_addr,
    output logic             win_enabled
);
    import upwb_pkg::*;

    // ------------------------------------------------------------------
    // Writable mask
    // ------------------------------------------------------------------

    // The setup bits pick the writable base bits within the legal range
    // of the space type, and the bits above the largest size are kept.
    function automatic logic [31:0] upwb_wmask(input logic [31:0] setup);
        logic [31:0] m;
        m = 32'h0000_0000;
        if (setup[UPWB_ENABLE_BIT]) begin
            if (setup[UPWB_SPACE_BIT]) begin
                m = (setup & UPWB_IO_LEGAL) | UPWB_IO_FIXED; // RL9
            end else begin
                m = (setup & UPWB_MEM_LEGAL) | UPWB_MEM_FIXED; // RL8
            end
        end
        return m & UPWB_ADDR_MASK; // RL11
    endfunction

    // Register select for the captured access.
    function automatic logic upwb_sel(input logic [7:0] addr, input logic [7:0] ofs);
        return addr == ofs;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------

    upwb_reg_if  rif ();
    upwb_win_if  win ();

    logic [31:0] base_ff;
    logic [31:0] setup_ff;
    logic [31:0] xbase_ff;
    logic [31:0] rdata_ff;
    logic        enabled_ff;
    logic [31:0] wmask;
    logic [31:0] be_mask;
    logic [31:0] base_view;
    logic        wr_base;
    logic        wr_setup;
    logic        wr_xbase;
    logic        rd_stb;

    assign wmask    = upwb_wmask(setup_ff); // RL4 RL5
    assign wr_base  = rif.acc_stb && rif.acc_wr && upwb_sel(rif.acc_addr, UPWB_BASE_OFS);
    assign wr_setup = rif.acc_stb && rif.acc_wr && upwb_sel(rif.acc_addr, UPWB_SETUP_OFS);
    assign wr_xbase = rif.acc_stb && rif.acc_wr && upwb_sel(rif.acc_addr, UPWB_XBASE_OFS);
    assign rd_stb   = rif.acc_stb && !rif.acc_wr;

    // Byte enables widened to a bit mask.
    genvar lane;
    generate
        for (lane = 0; lane < 4; lane++) begin : g_lane
            assign be_mask[lane*8 +: 8] = {8{rif.acc_be[lane]}};
        end
    endgenerate

    // Attribute bits follow the setup register; address bits outside the
    // writable mask read as zero.
    assign base_view = (base_ff & wmask)
                       | (setup_ff & UPWB_ATTR_MASK); // RL1 RL2 RL3 RL5

    // ------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------

    upwb_bus_port u_bus_port (
        .sys_clk     (sys_clk),
        .reset       (reset),
        .address     (address),
        .read        (read),
        .write       (write),
        .writedata   (writedata),
        .byteenable  (byteenable),
        .waitrequest (waitrequest),
        .rif         (rif)
    );

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    // Only bits that are both in the writable mask and byte-enabled change.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            base_ff <= UPWB_BASE_RST;
        end else if (wr_base) begin
            base_ff <= (base_ff & ~(wmask & be_mask))
                       | (rif.acc_wdata & wmask & be_mask); // RL4 RL11
        end
    end

    // The external loader wins over a bus write in the same cycle.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            setup_ff <= UPWB_SETUP_RST;
        end else if (ld_valid) begin
            setup_ff <= ld_data; // RL6
        end else if (wr_setup) begin
            setup_ff <= (setup_ff & ~be_mask) | (rif.acc_wdata & be_mask); // RL5
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            xbase_ff <= UPWB_XBASE_RST;
        end else if (wr_xbase) begin
            xbase_ff <= (xbase_ff & ~(be_mask & UPWB_ADDR_MASK))
                        | (rif.acc_wdata & be_mask & UPWB_ADDR_MASK); // RL10
        end
    end

    // Read data is sampled at the access strobe; unmapped offsets read zero.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rdata_ff <= 32'h0000_0000;
        end else if (rd_stb) begin
            case (rif.acc_addr)
                UPWB_BASE_OFS:  rdata_ff <= base_view;
                UPWB_SETUP_OFS: rdata_ff <= setup_ff;
                UPWB_XBASE_OFS: rdata_ff <= xbase_ff;
                default:        rdata_ff <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            enabled_ff <= 1'b0;
        end else begin
            enabled_ff <= setup_ff[UPWB_ENABLE_BIT]; // RL7
        end
    end

    assign readdata    = rdata_ff;
    assign win_enabled = enabled_ff;

    // ------------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------------

    assign win.enable = setup_ff[UPWB_ENABLE_BIT]; // RL7
    assign win.is_io  = setup_ff[UPWB_SPACE_BIT];
    assign win.mask   = wmask;
    assign win.base   = base_ff & wmask;
    assign win.xbase  = xbase_ff; // RL10

    upwb_decode u_decode (
        .sys_clk   (sys_clk),
        .reset     (reset),
        .win       (win),
        .up_valid  (up_valid),
        .up_is_io  (up_is_io),
        .up_addr   (up_addr),
        .hit       (up_hit),
        .xlat_addr (up_xlat_addr)
    );

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    logic base_rd;
    assign base_rd = rd_stb && upwb_sel(rif.acc_addr, UPWB_BASE_OFS);

    space_bit_a: assert property ( // RL1
        base_rd |=> rdata_ff[UPWB_SPACE_BIT] == $past(setup_ff[UPWB_SPACE_BIT]))
        else $error("Space bit does not follow the setup register.");

    type_field_a: assert property ( // RL2
        base_rd |=> rdata_ff[UPWB_TYPE_MSB:UPWB_TYPE_LSB]
                    == $past(setup_ff[UPWB_TYPE_MSB:UPWB_TYPE_LSB]))
        else $error("Decode width field does not follow the setup register.");

    pref_flag_a: assert property ( // RL3
        base_rd |=> rdata_ff[UPWB_PREF_BIT] == $past(setup_ff[UPWB_PREF_BIT]))
        else $error("Prefetchable flag does not follow the setup register.");

    ro_hold_a: assert property ( // RL4
        wr_base |=> ((base_ff ^ $past(base_ff)) & ~$past(wmask)) == 32'h0000_0000)
        else $error("A read-only base bit changed on a write.");

    rw_take_a: assert property ( // RL4
        wr_base && rif.acc_be == 4'hf
        |=> (base_ff & $past(wmask)) == ($past(rif.acc_wdata) & $past(wmask)))
        else $error("A writable base bit did not take the written value.");

    base_hold_a: assert property ( // RL4
        !wr_base |=> $stable(base_ff))
        else $error("Base register changed without a write.");

    setup_bus_a: assert property ( // RL5
        wr_setup && rif.acc_be == 4'hf && !ld_valid
        |=> setup_ff == $past(rif.acc_wdata))
        else $error("Setup register missed a bus write.");

    loader_a: assert property ( // RL6
        ld_valid |=> setup_ff == $past(ld_data))
        else $error("Setup register missed a loader value.");

    disable_a: assert property ( // RL7
        !setup_ff[UPWB_ENABLE_BIT] |-> wmask == 32'h0000_0000 ##1 !up_hit)
        else $error("Disabled window still decodes.");

    mem_range_a: assert property ( // RL8
        setup_ff[UPWB_ENABLE_BIT] && !setup_ff[UPWB_SPACE_BIT]
        |-> wmask[11:0] == 12'h000 && wmask[31])
        else $error("Memory window outside 4KB to 2GB.");

    io_range_a: assert property ( // RL9
        setup_ff[UPWB_ENABLE_BIT] && setup_ff[UPWB_SPACE_BIT]
        |-> wmask[31:8] == 24'hff_ffff && wmask[5:0] == 6'h00)
        else $error("I/O window outside 64 to 256 bytes.");

    xlat_a: assert property ( // RL10
        up_valid && $stable(xbase_ff) ##1 up_hit
        |-> ((up_xlat_addr ^ $past(xbase_ff)) & $past(wmask)) == 32'h0000_0000
            && ((up_xlat_addr ^ $past(up_addr)) & ~$past(wmask)) == 32'h0000_0000)
        else $error("Translated address is wrong.");

    rsv_zero_a: assert property ( // RL11
        base_rd |=> rdata_ff[5:4] == 2'b00)
        else $error("Reserved base bits read nonzero.");

    attr_ro_a: assert property ( // RL3
        wr_base && !ld_valid |=> setup_ff[3:0] == $past(setup_ff[3:0]))
        else $error("A base write changed the attribute bits.");

    base_view_a: assert property ( // RL4
        base_rd |=> (rdata_ff & ~UPWB_ATTR_MASK) == ($past(base_ff) & $past(wmask)))
        else $error("Base read shows a bit that is not writable.");

    be_lane_a: assert property ( // RL4
        wr_base |=> ((base_ff ^ $past(base_ff)) & ~$past(be_mask)) == 32'h0000_0000)
        else $error("A base write changed a disabled byte lane.");

    mem_sub_a: assert property ( // RL4
        setup_ff[UPWB_ENABLE_BIT] && !setup_ff[UPWB_SPACE_BIT]
        |-> (wmask & ~setup_ff) == 32'h0000_0000)
        else $error("Memory base bit writable without its setup bit.");

    io_sub_a: assert property ( // RL4
        setup_ff[UPWB_ENABLE_BIT] && setup_ff[UPWB_SPACE_BIT]
        |-> (wmask & ~(setup_ff | UPWB_IO_FIXED)) == 32'h0000_0000)
        else $error("I/O base bit writable without its setup bit.");

    setup_hold_a: assert property ( // RL5
        !wr_setup && !ld_valid |=> $stable(setup_ff))
        else $error("Setup register changed without a write or load.");

    enable_copy_a: assert property ( // RL7
        win_enabled == $past(setup_ff[UPWB_ENABLE_BIT]))
        else $error("Enable output does not follow the setup register.");

    xbase_take_a: assert property ( // RL10
        wr_xbase && rif.acc_be == 4'hf
        |=> xbase_ff == ($past(rif.acc_wdata) & UPWB_ADDR_MASK))
        else $error("Translated base missed a bus write.");

    xbase_hold_a: assert property ( // RL10
        !wr_xbase |=> $stable(xbase_ff))
        else $error("Translated base changed without a write.");

    base_rsv_a: assert property ( // RL11
        base_ff[5:0] == 6'h00)
        else $error("Reserved base bits were stored.");

    // ------------------------------------------------------------------
    // Decode checks
    // ------------------------------------------------------------------

    hit_space_a: assert property ( // RL1
        up_valid && (up_is_io != setup_ff[UPWB_SPACE_BIT]) |=> !up_hit)
        else $error("Transaction of the other space hit the window.");

    hit_idle_a: assert property (
        !up_valid |=> !up_hit)
        else $error("Window hit without a transaction.");

    // ------------------------------------------------------------------
    // Bus checks
    // ------------------------------------------------------------------

    answer_time_a: assert property (
        (read || write) && waitrequest && $past(waitrequest) && $past(!rif.acc_stb)
        && $past(waitrequest, 2)
        |-> ##[1:2] !waitrequest)
        else $error("Bus request not answered in time.");

    answer_now_a: assert property (
        rif.acc_stb |=> !waitrequest)
        else $error("Access strobe not answered in the next cycle.");

    wait_pulse_a: assert property (
        !waitrequest |=> waitrequest)
        else $error("Waitrequest stayed low for more than a cycle.");

    rdata_hold_a: assert property (
        !rd_stb |=> $stable(rdata_ff))
        else $error("Read data changed without a read.");

    unmapped_rd_a: assert property (
        rd_stb && !base_rd && !upwb_sel(rif.acc_addr, UPWB_SETUP_OFS)
        && !upwb_sel(rif.acc_addr, UPWB_XBASE_OFS) |=> rdata_ff == 32'h0000_0000)
        else $error("Unmapped offset read nonzero.");

    io_hit_c: cover property (up_hit && setup_ff[UPWB_SPACE_BIT]);
    mem_hit_c: cover property (up_hit && !setup_ff[UPWB_SPACE_BIT]);
    ro_write_c: cover property (wr_base && (wmask != UPWB_ADDR_MASK));
    load_c: cover property (ld_valid ##1 wr_base);
    disable_c: cover property (setup_ff[UPWB_ENABLE_BIT] ##1 !setup_ff[UPWB_ENABLE_BIT]);

endmodule

/* File: verification/tb.sv */
// Self-checking testbench for the upstream window 1 base address block.
`timescale 1ns/1ns
module tb;
    import upwb_pkg::*;

    logic        sys_clk;
    logic        reset;
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        ld_valid;
    logic [31:0] ld_data;
    logic        up_valid;
    logic        up_is_io;
    logic [31:0] up_addr;
    logic        up_hit;
    logic [31:0] up_xlat_addr;
    logic        win_enabled;
    logic [31:0] rd;
    logic [31:0] xb;
    logic [31:0] setups [5];
    int          num_errors;
    int          compares;

    upwb_top uut (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .address      (address),
        .read         (read),
        .write        (write),
        .writedata    (writedata),
        .byteenable   (byteenable),
        .readdata     (readdata),
        .waitrequest  (waitrequest),
        .ld_valid     (ld_valid),
        .ld_data      (ld_data),
        .up_valid     (up_valid),
        .up_is_io     (up_is_io),
        .up_addr      (up_addr),
        .up_hit       (up_hit),
        .up_xlat_addr (up_xlat_addr),
        .win_enabled  (win_enabled)
    );

    // ------------------------------------------------------------
    // Clock, watchdog and verdict
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    initial begin
        #50000;
        num_errors = num_errors + 1;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end

    task automatic report_and_stop();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Compare tasks and expected-value helpers
    // ------------------------------------------------------------
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares = compares + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp, input string what);
        compares = compares + 1;
        if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("[ERR] %0t %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    // Writable base bits for a given setup value.
    function automatic logic [31:0] wmask(input logic [31:0] s);
        if (!s[31]) begin
            return 32'h0000_0000;
        end
        if (s[0]) begin
            return (s & 32'hffff_ffc0) | 32'hffff_ff00;
        end
        return (s & 32'hffff_f000) | 32'h8000_0000;
    endfunction

    function automatic logic [31:0] xl(input logic [31:0] a, input logic [31:0] m);
        return (xb & m) | (a & ~m);
    endfunction

    // ------------------------------------------------------------
    // Bus, loader and upstream drivers
    // ------------------------------------------------------------
    task automatic bus_access(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                              input logic [3:0] be, output logic [31:0] q);
        address <= addr;
        writedata <= data;
        byteenable <= be;
        if (wr) begin
            write <= 1'b1;
        end else begin
            read <= 1'b1;
        end
        // A slave that never answers is caught by the watchdog.
        do begin
            @(posedge sys_clk);
        end while (waitrequest !== 1'b0);
        q = readdata;
        write <= 1'b0;
        read <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic bus_write(input logic [7:0] addr, input logic [31:0] data,
                             input logic [3:0] be);
        logic [31:0] dummy;
        bus_access(1'b1, addr, data, be, dummy);
    endtask

    task automatic bus_read(input logic [7:0] addr);
        bus_access(1'b0, addr, 32'h0000_0000, 4'hf, rd);
    endtask

    task automatic load_setup(input logic [31:0] v);
        ld_valid <= 1'b1;
        ld_data <= v;
        @(posedge sys_clk);
        ld_valid <= 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk);
    endtask

    task automatic probe(input logic [31:0] a, input logic io, input logic exp_hit,
                         input logic [31:0] m);
        up_valid <= 1'b1;
        up_addr <= a;
        up_is_io <= io;
        @(posedge sys_clk);
        up_valid <= 1'b0;
        @(posedge sys_clk);
        check_bit(up_hit, exp_hit, "window hit");
        check_word(up_xlat_addr, xl(a, m), "translated address");
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        num_errors = 0;
        compares = 0;
        reset = 1'b1;
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'h0;
        ld_valid = 1'b0;
        ld_data = 32'h0000_0000;
        up_valid = 1'b0;
        up_is_io = 1'b0;
        up_addr = 32'h0000_0000;
        xb = 32'h0000_0000;
        setups = '{32'hffff_fffa, 32'h8000_0000, 32'hffff_ffc1, 32'h8000_0001,
                   32'h7fff_fff0};
        repeat (6) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        @(posedge sys_clk);
        check_bit(waitrequest, 1'b1, "idle waitrequest");
        check_bit(win_enabled, 1'b0, "enable after reset");
        bus_read(UPWB_BASE_OFS);
        check_word(rd, 32'h0000_0000, "base reset");
        bus_read(UPWB_SETUP_OFS);
        check_word(rd, 32'h0000_0000, "setup reset");
        bus_read(UPWB_XBASE_OFS);
        check_word(rd, 32'h0000_0000, "translated base reset");
        bus_write(UPWB_BASE_OFS, 32'hffff_ffff, 4'hf);
        bus_read(UPWB_BASE_OFS);
        check_word(rd, 32'h0000_0000, "base locked while disabled");
        probe(32'h0000_0000, 1'b0, 1'b0, 32'h0000_0000);
        bus_write(8'h5c, 32'hffff_ffff, 4'hf);
        bus_read(8'h5c);
        check_word(rd, 32'h0000_0000, "unmapped read");
        for (int i = 0; i < 5; i++) begin
            bus_write(UPWB_SETUP_OFS, setups[i], 4'hf);
            bus_read(UPWB_SETUP_OFS);
            check_word(rd, setups[i], "setup readback");
            bus_write(UPWB_BASE_OFS, 32'hffff_ffff, 4'hf);
            bus_read(UPWB_BASE_OFS);
            check_word(rd, wmask(setups[i]) | {28'h0, setups[i][3:0]}, "base size");
        end
        // A 1MB prefetchable 64-bit memory window.
        bus_write(UPWB_SETUP_OFS, 32'hfff0_000a, 4'hf);
        bus_write(UPWB_BASE_OFS, 32'h1234_5678, 4'hf);
        bus_read(UPWB_BASE_OFS);
        check_word(rd, 32'h1230_000a, "memory base");
        bus_write(UPWB_XBASE_OFS, 32'habcd_ef3f, 4'hf);
        bus_read(UPWB_XBASE_OFS);
        xb = 32'habcd_ef00;
        check_word(rd, xb, "translated base");
        check_bit(win_enabled, 1'b1, "window enabled");
        probe(32'h123a_bcde, 1'b0, 1'b1, 32'hfff0_0000);
        probe(32'h1240_0000, 1'b0, 1'b0, 32'hfff0_0000);
        probe(32'h123a_bcde, 1'b1, 1'b0, 32'hfff0_0000);
        bus_write(UPWB_BASE_OFS, 32'h5600_0000, 4'b1000);
        bus_read(UPWB_BASE_OFS);
        check_word(rd, 32'h5630_000a, "byte lane write");
        probe(32'h563f_ffff, 1'b0, 1'b1, 32'hfff0_0000);
        // A 64-byte I/O window set up by the loader.
        load_setup(32'hffff_ffc1);
        bus_read(UPWB_SETUP_OFS);
        check_word(rd, 32'hffff_ffc1, "loaded setup");
        bus_write(UPWB_BASE_OFS, 32'h0000_1240, 4'hf);
        bus_read(UPWB_BASE_OFS);
        check_word(rd, 32'h0000_1241, "io base");
        probe(32'h0000_127f, 1'b1, 1'b1, 32'hffff_ffc0);
        probe(32'h0000_1280, 1'b1, 1'b0, 32'hffff_ffc0);
        probe(32'h0000_123f, 1'b1, 1'b0, 32'hffff_ffc0);
        probe(32'h0000_1250, 1'b0, 1'b0, 32'hffff_ffc0);
        load_setup(32'h7fff_ffc1);
        check_bit(win_enabled, 1'b0, "window disabled");
        probe(32'h0000_1250, 1'b1, 1'b0, 32'h0000_0000);
        bus_read(UPWB_BASE_OFS);
        check_word(rd, 32'h0000_0001, "base locked");
        report_and_stop();
    end
endmodule
